// *** aasd_consts.svh ***
// Offsets, field positions, reset values and timing counts for the strap decoder.
// Assumes it is included by bare name into each file that needs it.
`ifndef AASD_CONSTS_SVH
`define AASD_CONSTS_SVH

`define AASD_OFS_NODE_ADDR 8'h00
`define AASD_OFS_STATUS    8'h04
`define AASD_OFS_CTRL      8'h08
`define AASD_OFS_IRQ_STS   8'h0c
`define AASD_OFS_IRQ_CLR   8'h10
`define AASD_OFS_IRQ_EN    8'h14

`define AASD_CTRL_INIT_DONE 0
`define AASD_CTRL_SW_FAULT  1
`define AASD_CTRL_RESET     2'h0
`define AASD_IRQ_EN_RESET   3'h0

`define AASD_IRQ_FAULT 0
`define AASD_IRQ_STO   1
`define AASD_IRQ_READY 2

`define AASD_ADDR_DEFAULT  9'h0ff
`define AASD_VENDOR_OFFSET 9'h080

`define AASD_THR_1 8'h29
`define AASD_THR_2 8'h6d
`define AASD_THR_3 8'h9b
`define AASD_THR_4 8'hbc
`define AASD_THR_5 8'hd4
`define AASD_THR_6 8'he9
`define AASD_THR_7 8'hf9

`define AASD_CLK_HZ          25000000
`define AASD_BLINK_PERIOD_MS 1000
`define AASD_BLINK_HALF_CYC  ((`AASD_CLK_HZ / 1000) * `AASD_BLINK_PERIOD_MS / 2)

`define AASD_RESP_OKAY   2'h0
`define AASD_RESP_SLVERR 2'h2

`endif

// *** aasd_pkg.sv ***
// Types shared by the strap decoder modules.
// Assumes nothing beyond a SystemVerilog compiler.
package aasd_pkg;
	typedef enum logic [1:0] {
		ST_CAPTURE,
		ST_INIT,
		ST_READY,
		ST_LSS_IDLE
	} aasd_state_type;

	typedef logic [2:0] aasd_strap_type;

	typedef enum logic [2:0] {
		SEL_NODE_ADDR,
		SEL_STATUS,
		SEL_CTRL,
		SEL_IRQ_STS,
		SEL_IRQ_CLR,
		SEL_IRQ_EN,
		SEL_NONE
	} aasd_sel_type;
endpackage

// *** aasd_strap_level.sv ***
// Turns one sampled strap level into a value from 0 to 7.
// Assumes the level is an 8-bit converter code where full scale is the 3.3 V rail.
`include "aasd_consts.svh"

module aasd_strap_level (
	input  wire logic [7:0]              level,
	output      aasd_pkg::aasd_strap_type value
);
	wire logic [6:0] above;

	// Seven ascending thresholds split the rail into eight bands.
	assign above[0] = (level >= `AASD_THR_1);
	assign above[1] = (level >= `AASD_THR_2);
	assign above[2] = (level >= `AASD_THR_3);
	assign above[3] = (level >= `AASD_THR_4);
	assign above[4] = (level >= `AASD_THR_5);
	assign above[5] = (level >= `AASD_THR_6);
	assign above[6] = (level >= `AASD_THR_7);

	assign value = 3'(above[0]) + 3'(above[1]) + 3'(above[2]) + 3'(above[3])
		+ 3'(above[4]) + 3'(above[5]) + 3'(above[6]);
endmodule

// *** aasd_blink.sv ***
// Half-period divider that drives the flashing phase of the ready indicator.
// Assumes a single clock and a synchronous active-high reset.
module aasd_blink #(
	parameter int HALF_CYCLES = 12500000
) (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic run,
	output      logic phase_q
);
	logic [23:0] cnt_q;
	wire  logic  wrap;

	assign wrap = (cnt_q == 24'(HALF_CYCLES - 1));

	// Equal on and off halves; the phase restarts lit each time flashing begins.
	always_ff @(posedge core_clk) begin
		if (srst || !run) begin
			cnt_q   <= 24'h000000;
			phase_q <= 1'b1;
		end else if (wrap) begin
			cnt_q   <= 24'h000000;
			phase_q <= !phase_q;
		end else begin
			cnt_q <= cnt_q + 24'h000001;
		end
	end
endmodule

// *** aasd_top.sv ***
// Strap address decoder with indicator drive, torque-off gating and an AXI4-Lite slave.
// Assumes strap levels are converter codes synchronous to core_clk and stable at reset release.
// What this block does
// - Pack low, middle strap values into bits 0-2, 3-5 and the low two bits of the high strap into bits 6-7.
// - Address bit 8 always reads as zero whatever the high strap decodes.
// - Bit 7 set selects vendor CAN mode, clear selects CANopen mode.
// - Outside the default case the usable address never exceeds 127.
// - Vendor mode address is 64*(high mod 4) minus 128 plus 8*mid plus low.
// - CANopen address is 64*(high mod 4) plus 8*mid plus low.
// - All straps at zero report address 255 in CANopen mode.
// - Default case enters LSS inactive and flashes green with one-second period.
// - Red fault indicator lights whenever an error condition is present.
// - Green ready indicator lights once initialization after power-on completes.
// - Green ready indicator goes dark as soon as an error occurs.
// - PWM outputs run only while both safe-torque-off inputs are energized.
`include "aasd_consts.svh"

module aasd_top #(
	parameter int BLINK_HALF_CYCLES = `AASD_BLINK_HALF_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  addr_strap_low,
	input  wire logic [7:0]  addr_strap_mid,
	input  wire logic [7:0]  addr_strap_high,
	input  wire logic        safe_off_in_a_pos,
	input  wire logic        safe_off_in_a_neg,
	input  wire logic        safe_off_in_b_pos,
	input  wire logic        safe_off_in_b_neg,
	input  wire logic        drive_fault,
	input  wire logic [2:0]  pwm_in,
	output      logic [2:0]  pwm_out_q,
	output      logic        ready_indicator_q,
	output      logic        fault_indicator_q,
	output      logic        vendor_can_mode_q,
	output      logic        lss_inactive_q,
	output      logic        irq_q,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	function automatic aasd_pkg::aasd_sel_type reg_sel(input logic [7:0] addr);
		unique case (addr)
			`AASD_OFS_NODE_ADDR: reg_sel = aasd_pkg::SEL_NODE_ADDR;
			`AASD_OFS_STATUS:    reg_sel = aasd_pkg::SEL_STATUS;
			`AASD_OFS_CTRL:      reg_sel = aasd_pkg::SEL_CTRL;
			`AASD_OFS_IRQ_STS:   reg_sel = aasd_pkg::SEL_IRQ_STS;
			`AASD_OFS_IRQ_CLR:   reg_sel = aasd_pkg::SEL_IRQ_CLR;
			`AASD_OFS_IRQ_EN:    reg_sel = aasd_pkg::SEL_IRQ_EN;
			default:             reg_sel = aasd_pkg::SEL_NONE;
		endcase
	endfunction

	aasd_pkg::aasd_state_type state_q;
	aasd_pkg::aasd_state_type state_d;
	aasd_pkg::aasd_strap_type low_val;
	aasd_pkg::aasd_strap_type mid_val;
	aasd_pkg::aasd_strap_type high_val;

	logic [8:0] raw_q;
	logic [8:0] node_address_q;
	logic       unstrapped_q;
	logic [1:0] ctrl_q;
	logic [2:0] irq_sts_q;
	logic [2:0] irq_en_q;
	logic       error_q;
	logic       sto_ok_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	wire logic [8:0] raw_addr;
	wire logic       all_zero;
	wire logic [8:0] calc_addr;
	wire logic       error_now;
	wire logic       sto_a_on;
	wire logic       sto_b_on;
	wire logic       sto_both;
	wire logic       blink_phase;
	wire logic       ready_d;
	wire logic       do_write;
	wire logic       lane0;
	wire logic [2:0] irq_event;
	wire logic [2:0] irq_clear;
	wire logic [2:0] irq_sts_d;
	wire logic [31:0] status_word;
	wire logic [31:0] read_word;
	wire logic        read_ok;
	wire aasd_pkg::aasd_sel_type wsel;
	wire aasd_pkg::aasd_sel_type rsel;

	aasd_strap_level u_low (
		.level (addr_strap_low),
		.value (low_val)
	);
	aasd_strap_level u_mid (
		.level (addr_strap_mid),
		.value (mid_val)
	);
	aasd_strap_level u_high (
		.level (addr_strap_high),
		.value (high_val)
	);

	aasd_blink #(
		.HALF_CYCLES (BLINK_HALF_CYCLES)
	) u_blink (
		.core_clk (core_clk),
		.srst     (srst),
		.run      (state_q == aasd_pkg::ST_LSS_IDLE),
		.phase_q  (blink_phase)
	);

	// The top strap bit is dropped on purpose, so bit 7 is the mode select.
	assign raw_addr = {1'b0, high_val[1:0], mid_val, low_val};
	assign all_zero = (low_val == 3'h0) && (mid_val == 3'h0) && (high_val == 3'h0);
	// With bit 8 forced low, subtracting 128 in vendor mode leaves bits 0 to 6 only.
	assign calc_addr = all_zero ? `AASD_ADDR_DEFAULT :
		raw_addr[7] ? (raw_addr - `AASD_VENDOR_OFFSET) :
		raw_addr;

	assign sto_a_on  = safe_off_in_a_pos && !safe_off_in_a_neg;
	assign sto_b_on  = safe_off_in_b_pos && !safe_off_in_b_neg;
	assign sto_both  = sto_a_on && sto_b_on;
	assign error_now = drive_fault || ctrl_q[`AASD_CTRL_SW_FAULT];

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			aasd_pkg::ST_CAPTURE: begin
				state_d = all_zero ? aasd_pkg::ST_LSS_IDLE : aasd_pkg::ST_INIT;
			end
			aasd_pkg::ST_INIT: begin
				if (ctrl_q[`AASD_CTRL_INIT_DONE]) begin
					state_d = aasd_pkg::ST_READY;
				end
			end
			aasd_pkg::ST_READY: begin
				state_d = aasd_pkg::ST_READY;
			end
			aasd_pkg::ST_LSS_IDLE: begin
				state_d = aasd_pkg::ST_LSS_IDLE;
			end
		endcase
	end

	// An error wins over both the steady and the flashing green.
	assign ready_d = !error_now && ((state_q == aasd_pkg::ST_READY) ||
		((state_q == aasd_pkg::ST_LSS_IDLE) && blink_phase));

	// Straps are read only in the first cycle after reset, so later drift is ignored.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q        <= aasd_pkg::ST_CAPTURE;
			raw_q          <= 9'h000;
			node_address_q <= 9'h000;
			unstrapped_q   <= 1'b0;
			vendor_can_mode_q <= 1'b0;
			lss_inactive_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == aasd_pkg::ST_CAPTURE) begin
				raw_q          <= raw_addr;
				node_address_q <= calc_addr;
				unstrapped_q   <= all_zero;
				vendor_can_mode_q <= raw_addr[7] && !all_zero;
				lss_inactive_q <= all_zero;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ready_indicator_q <= 1'b0;
			fault_indicator_q <= 1'b0;
			error_q           <= 1'b0;
			sto_ok_q          <= 1'b0;
			pwm_out_q         <= 3'h0;
		end else begin
			ready_indicator_q <= ready_d;
			fault_indicator_q <= error_now;
			error_q           <= error_now;
			sto_ok_q          <= sto_both;
			pwm_out_q         <= sto_both ? pwm_in : 3'h0;
		end
	end

	assign irq_event[`AASD_IRQ_FAULT] = error_now && !error_q;
	assign irq_event[`AASD_IRQ_STO]   = sto_ok_q && !sto_both;
	assign irq_event[`AASD_IRQ_READY] = ready_d && !ready_indicator_q && (state_q == aasd_pkg::ST_READY);

	assign wsel      = reg_sel(aw_addr_q);
	assign rsel      = reg_sel(s_axi_araddr);
	assign do_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign lane0     = w_strb_q[0];
	assign irq_clear = (do_write && lane0 && (wsel == aasd_pkg::SEL_IRQ_CLR)) ? w_data_q[2:0] : 3'h0;
	// A new event in the clearing cycle survives the clear.
	assign irq_sts_d = (irq_sts_q & ~irq_clear) | irq_event;

	assign status_word = {24'h000000, |pwm_out_q, sto_b_on, sto_a_on, fault_indicator_q,
		ready_indicator_q, lss_inactive_q, unstrapped_q, vendor_can_mode_q};
	assign read_ok = (rsel != aasd_pkg::SEL_NONE) && (rsel != aasd_pkg::SEL_IRQ_CLR);
	assign read_word =
		(rsel == aasd_pkg::SEL_NODE_ADDR) ? {23'h000000, node_address_q} :
		(rsel == aasd_pkg::SEL_STATUS)    ? status_word :
		(rsel == aasd_pkg::SEL_CTRL)      ? {30'h00000000, ctrl_q} :
		(rsel == aasd_pkg::SEL_IRQ_STS)   ? {29'h00000000, irq_sts_q} :
		(rsel == aasd_pkg::SEL_IRQ_EN)    ? {29'h00000000, irq_en_q} :
		32'h00000000;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_sts_q <= 3'h0;
			irq_en_q  <= `AASD_IRQ_EN_RESET;
			ctrl_q    <= `AASD_CTRL_RESET;
			irq_q     <= 1'b0;
		end else begin
			irq_sts_q <= irq_sts_d;
			irq_q     <= |(irq_sts_d & irq_en_q);
			if (do_write && lane0 && (wsel == aasd_pkg::SEL_IRQ_EN)) begin
				irq_en_q <= w_data_q[2:0];
			end
			if (do_write && lane0 && (wsel == aasd_pkg::SEL_CTRL)) begin
				ctrl_q <= w_data_q[1:0];
			end
		end
	end

	// Address and data are parked separately, so they may arrive in either order.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AASD_RESP_OKAY;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr_q     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= ((wsel == aasd_pkg::SEL_CTRL) || (wsel == aasd_pkg::SEL_IRQ_CLR) ||
					(wsel == aasd_pkg::SEL_IRQ_EN)) ? `AASD_RESP_OKAY : `AASD_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `AASD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= read_word;
			s_axi_rresp   <= read_ok ? `AASD_RESP_OKAY : `AASD_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence capture_done;
		state_q == aasd_pkg::ST_CAPTURE ##1 state_q != aasd_pkg::ST_CAPTURE;
	endsequence

	sequence canopen_latched;
		!unstrapped_q && !raw_q[7];
	endsequence

	AST_PACK_FIELDS: assert property (capture_done ##0 canopen_latched |->
		node_address_q == {1'b0, raw_q[7:0]}) else $error("node address not packed from straps");
	AST_BIT8_ZERO: assert property (node_address_q[8] == 1'b0)
		else $error("strap bit 8 not forced low");
	AST_MODE_FROM_BIT7: assert property (state_q != aasd_pkg::ST_CAPTURE |->
		vendor_can_mode_q == (raw_q[7] && !unstrapped_q)) else $error("mode not taken from bit 7");
	AST_ADDR_LIMIT: assert property (state_q != aasd_pkg::ST_CAPTURE && !unstrapped_q |->
		node_address_q <= 9'h07f) else $error("strapped address above 127");
	AST_VENDOR_FORMULA: assert property (capture_done ##0 vendor_can_mode_q |->
		node_address_q == 9'(raw_q - 9'h080)) else $error("vendor mode address wrong");
	AST_CANOPEN_FORMULA: assert property (state_q == aasd_pkg::ST_READY && !vendor_can_mode_q |->
		node_address_q == {1'b0, raw_q[7:6], raw_q[5:3], raw_q[2:0]}) else $error("canopen address wrong");
	AST_DEFAULT_ADDR: assert property (capture_done ##0 unstrapped_q |->
		node_address_q == 9'h0ff && !vendor_can_mode_q && lss_inactive_q) else $error("default case wrong");
	AST_LSS_STATE: assert property (lss_inactive_q |-> state_q == aasd_pkg::ST_LSS_IDLE)
		else $error("default case left lss inactive");
	AST_FAULT_LED: assert property (error_now |=> fault_indicator_q ##0 !ready_indicator_q)
		else $error("fault not shown or ready still lit");
	AST_READY_LED: assert property ($rose(ctrl_q[`AASD_CTRL_INIT_DONE]) && state_q == aasd_pkg::ST_INIT
		&& !error_now ##1 !error_now |=> ready_indicator_q) else $error("ready not lit after init");
	AST_STO_GATE: assert property (!sto_both |=> pwm_out_q == 3'h0)
		else $error("pwm running without both torque-off inputs");
	AST_BLINK_HALVES: assert property ($changed(ready_indicator_q) && lss_inactive_q && !error_now
		&& !$past(error_now) |=> $stable(ready_indicator_q)[*8]) else $error("blink phase too short");
endmodule

// *** aasd_board_model.sv ***
// Board-side model: strap resistor dividers and the torque-off supply pairs.
// Assumes the bench sets the wanted strap values and supply states at clock edges.
`include "aasd_consts.svh"

module aasd_board_model (
	input  wire logic [2:0] low_val,
	input  wire logic [2:0] mid_val,
	input  wire logic [2:0] high_val,
	input  wire logic       edge_sel,
	input  wire logic       sto_a_on,
	input  wire logic       sto_b_on,
	output      logic [7:0] low_lvl,
	output      logic [7:0] mid_lvl,
	output      logic [7:0] high_lvl,
	output      logic       a_pos,
	output      logic       a_neg,
	output      logic       b_pos,
	output      logic       b_neg
);
	// Edge codes sit exactly on a band's lower threshold, the worst case for a divider at tolerance.
	function automatic logic [7:0] lvl(input logic [2:0] v, input logic e);
		logic [7:0] nom [8];
		logic [7:0] thr [8];
		nom = '{8'h00, 8'h52, 8'h88, 8'hae, 8'hc9, 8'hdf, 8'hf1, 8'hff};
		thr = '{8'h00, `AASD_THR_1, `AASD_THR_2, `AASD_THR_3, `AASD_THR_4, `AASD_THR_5, `AASD_THR_6, `AASD_THR_7};
		return e ? thr[v] : nom[v];
	endfunction

	assign low_lvl = lvl(low_val, edge_sel);
	assign mid_lvl = lvl(mid_val, edge_sel);
	assign high_lvl = lvl(high_val, edge_sel);
	// An unpowered pair shows no voltage across it, so both lines sit low.
	assign a_pos = sto_a_on;
	assign a_neg = 1'b0;
	assign b_pos = sto_b_on;
	assign b_neg = 1'b0;
endmodule

// *** aasd_top_tb.sv ***
// Self-checking bench for the strap decoder: register reads, indicators and torque-off gating.
// Assumes the board model feeds strap levels and torque-off lines; one 25 MHz clock.
`include "aasd_consts.svh"

module aasd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 16;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [2:0]  sv_low = 3'h0, sv_mid = 3'h0, sv_high = 3'h0, pwm_in = 3'h0;
	logic        edge_sel = 1'b0, sto_a = 1'b0, sto_b = 1'b0, drive_fault = 1'b0;
	logic [7:0]  lvl_low, lvl_mid, lvl_high, awaddr = 8'h00, araddr = 8'h00;
	logic        a_pos, a_neg, b_pos, b_neg, ready_q, fault_q, vendor_q, lss_q, irq_q;
	logic [2:0]  pwm_out;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	int          error_cnt = 0;
	int          checks_done = 0;

	aasd_board_model aasd_board_model_inst (.low_val(sv_low), .mid_val(sv_mid), .high_val(sv_high),
		.edge_sel(edge_sel), .sto_a_on(sto_a), .sto_b_on(sto_b), .low_lvl(lvl_low), .mid_lvl(lvl_mid),
		.high_lvl(lvl_high), .a_pos(a_pos), .a_neg(a_neg), .b_pos(b_pos), .b_neg(b_neg));

	aasd_top #(.BLINK_HALF_CYCLES(HALF)) aasd_top_inst (.core_clk(core_clk), .srst(srst),
		.addr_strap_low(lvl_low), .addr_strap_mid(lvl_mid), .addr_strap_high(lvl_high),
		.safe_off_in_a_pos(a_pos), .safe_off_in_a_neg(a_neg), .safe_off_in_b_pos(b_pos),
		.safe_off_in_b_neg(b_neg), .drive_fault(drive_fault), .pwm_in(pwm_in), .pwm_out_q(pwm_out),
		.ready_indicator_q(ready_q), .fault_indicator_q(fault_q), .vendor_can_mode_q(vendor_q),
		.lss_inactive_q(lss_q), .irq_q(irq_q), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	initial begin
		forever #20 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("Mismatches %0d, comparisons %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// The master never assumes a latency; only the watchdog ends a wait on a dead slave.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				rsp = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic rdr(input logic [7:0] a);
		bit done;
		done = 1'b0;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rd = rdata;
				rsp = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic boot(input logic [2:0] h, input logic [2:0] m, input logic [2:0] l, input logic e);
		srst <= 1'b1;
		sv_high <= h;
		sv_mid <= m;
		sv_low <= l;
		edge_sel <= e;
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic wt(input logic v, output int n);
		n = 0;
		while (ready_q !== v && n < 100) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	function automatic logic [31:0] exp_addr(input logic [2:0] h, input logic [2:0] m, input logic [2:0] l);
		if ({h, m, l} == 9'h000) return 32'(`AASD_ADDR_DEFAULT);
		return {24'h0, h[1:0], m, l} - (h[1] ? 32'h80 : 32'h0);
	endfunction

	initial begin
		logic [2:0] th [7] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h4, 3'h6, 3'h3};
		logic [2:0] tm [7] = '{3'h0, 3'h7, 3'h3, 3'h7, 3'h3, 3'h2, 3'h6};
		logic [2:0] tl [7] = '{3'h0, 3'h5, 3'h4, 3'h7, 3'h2, 3'h1, 3'h1};
		logic       dflt;
		int         n;
		for (int i = 0; i < 7; i++) begin
			boot(th[i], tm[i], tl[i], i > 4);
			dflt = (i == 0);
			rdr(`AASD_OFS_NODE_ADDR);
			chk(rd, exp_addr(th[i], tm[i], tl[i]));
			chk(vendor_q, th[i][1] & ~dflt);
			chk(lss_q, dflt);
			rdr(`AASD_OFS_STATUS);
			chk(rd[2:0], {dflt, dflt, th[i][1] & ~dflt});
		end
		boot(3'h0, 3'h0, 3'h0, 1'b0);
		wt(1'b0, n);
		wt(1'b1, n);
		wt(1'b0, n);
		chk(n, HALF);
		wt(1'b1, n);
		chk(n, HALF);
		boot(3'h1, 3'h7, 3'h5, 1'b0);
		chk(ready_q, 1'b0);
		rdr(`AASD_OFS_CTRL);
		chk(rd, 32'h0);
		rdr(`AASD_OFS_IRQ_EN);
		chk(rd, 32'h0);
		wr(`AASD_OFS_IRQ_EN, 32'h7);
		wr(`AASD_OFS_CTRL, 32'h1);
		repeat (3) @(posedge core_clk);
		chk(ready_q, 1'b1);
		chk(irq_q, 1'b1);
		wr(`AASD_OFS_IRQ_CLR, 32'h4);
		rdr(`AASD_OFS_IRQ_STS);
		chk(rd, 32'h0);
		chk(irq_q, 1'b0);
		drive_fault <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk(fault_q, 1'b1);
		chk(ready_q, 1'b0);
		@(posedge core_clk);
		chk(irq_q, 1'b1);
		wr(`AASD_OFS_IRQ_EN, 32'h0);
		// The interrupt line follows a new enable one cycle after the write lands.
		@(posedge core_clk);
		chk(irq_q, 1'b0);
		drive_fault <= 1'b0;
		wr(`AASD_OFS_CTRL, 32'h3);
		repeat (2) @(posedge core_clk);
		chk(fault_q, 1'b1);
		chk(ready_q, 1'b0);
		wr(`AASD_OFS_IRQ_CLR, 32'h7);
		for (int i = 3; i >= 0; i--) begin
			sto_a <= i[0];
			sto_b <= i[1];
			pwm_in <= 3'(i + 2);
			repeat (3) @(posedge core_clk);
			chk(pwm_out, (i == 3) ? 3'(i + 2) : 3'h0);
		end
		rdr(`AASD_OFS_IRQ_STS);
		chk(rd[1], 1'b1);
		rdr(8'h18);
		chk(rsp, `AASD_RESP_SLVERR);
		chk(rd, 32'h0);
		rdr(`AASD_OFS_IRQ_CLR);
		chk(rsp, `AASD_RESP_SLVERR);
		wr(`AASD_OFS_NODE_ADDR, 32'h5);
		chk(rsp, `AASD_RESP_SLVERR);
		// A strap that moves after the latch must leave the address alone.
		sv_mid <= 3'h2;
		rdr(`AASD_OFS_NODE_ADDR);
		chk(rsp, `AASD_RESP_OKAY);
		chk(rd, 32'h0000007d);
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		end_sim();
	end
endmodule
